/* File: src/ecmr_defs.svh */
// constants of the engine controller holding-register bank
// assumes: included by bare name from the bank module and its checker
`ifndef ECMR_DEFS_SVH
`define ECMR_DEFS_SVH
// ==================================================
// register numbers
`define ECMR_A_HOURS_HI  16'h9C41
`define ECMR_A_HOURS_LO  16'h9C42
`define ECMR_A_SPEED     16'h9C43
`define ECMR_A_VOLTS     16'h9C44
`define ECMR_A_OIL       16'h9C45
`define ECMR_A_TEMP      16'h9C46
`define ECMR_A_STATE     16'h9C47
`define ECMR_A_SD_A      16'h9C48
`define ECMR_A_SD_B      16'h9C49
`define ECMR_A_SD_C      16'h9C4A
`define ECMR_A_LEVEL     16'h9C4B
`define ECMR_A_RUN_CMD   16'h9C4C
`define ECMR_A_MAX_SPD   16'h9C4D
`define ECMR_A_AMBIENT   16'h9C4E
`define ECMR_A_MODE      16'h9C4F
`define ECMR_A_LOAD_SPD  16'h9C50
`define ECMR_A_MAN_ONLY  16'h9C51
`define ECMR_A_PRE1      16'h9C52
`define ECMR_A_PRE2      16'h9C53
`define ECMR_A_SAVE      16'h9D30
// ==================================================
// field masks and values
`define ECMR_SD_A_MASK   16'h8FFF
`define ECMR_SD_B_MASK   16'hBB9F
`define ECMR_SD_C_MASK   16'h0001
`define ECMR_SAVE_VALUE  16'h0001
`define ECMR_FLAG_MAX    16'h0001
`define ECMR_WORD_RESET  16'h0000
`define ECMR_FLAG_RESET  1'h0
`define ECMR_NODE_DFLT   8'h01
`define ECMR_NODE_BCAST  8'h00
`define ECMR_EXC_NONE    8'h00
`define ECMR_EXC_ADDR    8'h02
`define ECMR_EXC_VALUE   8'h03
`endif

/* File: src/ecmr_pkg.sv */
// types of the engine controller holding-register bank
// assumes: compiled before the bank module
`default_nettype none
package ecmr_pkg;
	// ==================================================
	// controller state codes
	typedef enum logic [4:0] {
		ECMR_ST_STABILIZE = 5'h00, ECMR_ST_STOPPED  = 5'h01,
		ECMR_ST_STANDBY   = 5'h02, ECMR_ST_PRE1     = 5'h03,
		ECMR_ST_SAFE_CHK  = 5'h04, ECMR_ST_PRE2     = 5'h05,
		ECMR_ST_CRANK_ON  = 5'h06, ECMR_ST_CRANK_RST = 5'h07,
		ECMR_ST_FALSE_CHK = 5'h08, ECMR_ST_WARMUP   = 5'h09,
		ECMR_ST_FILL1     = 5'h0A, ECMR_ST_FILL2    = 5'h0B,
		ECMR_ST_LOADED    = 5'h0C, ECMR_ST_COOLDOWN = 5'h0D,
		ECMR_ST_ETS       = 5'h0E, ECMR_ST_SPINDOWN = 5'h0F,
		ECMR_ST_WAIT      = 5'h10
	} ecmr_ctrl_state_t;
	// telemetry from the controller core
	typedef struct packed {
		logic [31:0]      run_hours;
		logic [15:0]      engine_speed;
		logic [15:0]      supply_volts_x10;
		logic [15:0]      oil_kpa;
		logic [15:0]      engine_temp_c;
		logic [15:0]      ambient_temp_c;
		logic [15:0]      level_ft_x10;
		ecmr_ctrl_state_t state;
		logic [15:0]      shutdown_fault_a;
		logic [15:0]      shutdown_fault_b;
		logic [15:0]      shutdown_fault_c;
	} ecmr_telem_t;
	// writable settings
	typedef struct packed {
		logic        run_cmd;
		logic [15:0] max_speed;
		logic        auto_mode;
		logic [15:0] loaded_speed;
		logic        manual_only;
		logic        pre1_auto_only;
		logic        pre2_auto_only;
	} ecmr_settings_t;
	// request from the serial front end
	typedef struct packed {
		logic        valid;
		logic        write;
		logic [7:0]  node;
		logic [15:0] addr;
		logic [15:0] wdata;
	} ecmr_req_t;
	// answer to the serial front end
	typedef struct packed {
		logic        valid;
		logic [15:0] rdata;
		logic [7:0]  exc;
	} ecmr_rsp_t;
	// control handed to the engine sequencer
	typedef struct packed {
		logic        run_request;
		logic        auto_mode;
		logic        manual_only;
		logic        pre1_auto_only;
		logic        pre2_auto_only;
		logic [15:0] max_speed;
		logic [15:0] loaded_speed;
	} ecmr_ctrl_t;
endpackage : ecmr_pkg
`default_nettype wire

/* File: src/ecmr_regs.sv */
// holding-register bank seen by the serial master of the engine controller
// assumes: framing and crc are decoded elsewhere on the same clock; the
// persistent store and panel logic sit outside and share this clock
`timescale 1ns/1ps
`include "ecmr_defs.svh"
`default_nettype none
module ecmr_regs (
	// clock and reset
	input  wire logic                  i_sys_clk,
	input  wire logic                  i_rst_b,
	// serial register port
	input  wire ecmr_pkg::ecmr_req_t   i_req,
	output ecmr_pkg::ecmr_rsp_t        o_rsp,
	// node number from panel configuration
	input  wire logic [7:0]            i_node_cfg,
	input  wire logic                  i_node_load,
	// telemetry from the controller core
	input  wire ecmr_pkg::ecmr_telem_t i_telem,
	// persistent settings and local panel edits
	input  wire ecmr_pkg::ecmr_settings_t i_stored,
	input  wire logic                  i_stored_update,
	output ecmr_pkg::ecmr_settings_t   o_commit_data,
	output logic                       o_commit,
	// control to the engine sequencer
	output ecmr_pkg::ecmr_ctrl_t       o_ctrl,
	output logic [7:0]                 o_node
);
	// ==================================================
	// start-up sequencer
	typedef enum logic [2:0] {
		ECMR_BOOT_RESET = 3'b001,
		ECMR_BOOT_LOAD  = 3'b010,
		ECMR_BOOT_RUN   = 3'b100
	} ecmr_boot_t;

	ecmr_boot_t                boot;      // start-up phase
	ecmr_pkg::ecmr_settings_t  work;      // live, temporary settings
	logic [7:0]                node;      // our slave node number

	// ==================================================
	// decode helpers

	// true for a register that the master may write
	function automatic logic ecmr_is_rw(input logic [15:0] a);
		unique case (a)
			`ECMR_A_RUN_CMD, `ECMR_A_MAX_SPD, `ECMR_A_MODE,
			`ECMR_A_LOAD_SPD, `ECMR_A_MAN_ONLY, `ECMR_A_PRE1,
			`ECMR_A_PRE2, `ECMR_A_SAVE:
				ecmr_is_rw = 1'b1;
			default:
				ecmr_is_rw = 1'b0;
		endcase
	endfunction : ecmr_is_rw

	// true for a register that holds only zero or one
	function automatic logic ecmr_is_flag(input logic [15:0] a);
		unique case (a)
			`ECMR_A_RUN_CMD, `ECMR_A_MODE, `ECMR_A_MAN_ONLY,
			`ECMR_A_PRE1, `ECMR_A_PRE2:
				ecmr_is_flag = 1'b1;
			default:
				ecmr_is_flag = 1'b0;
		endcase
	endfunction : ecmr_is_flag

	// true for any mapped register
	function automatic logic ecmr_is_mapped(input logic [15:0] a);
		unique case (a)
			`ECMR_A_HOURS_HI, `ECMR_A_HOURS_LO, `ECMR_A_SPEED,
			`ECMR_A_VOLTS, `ECMR_A_OIL, `ECMR_A_TEMP,
			`ECMR_A_STATE, `ECMR_A_SD_A, `ECMR_A_SD_B,
			`ECMR_A_SD_C, `ECMR_A_LEVEL, `ECMR_A_AMBIENT:
				ecmr_is_mapped = 1'b1;
			default:
				ecmr_is_mapped = ecmr_is_rw(a);
		endcase
	endfunction : ecmr_is_mapped

	// ==================================================
	// request qualification

	logic addressed;   // request is for us
	logic bcast;       // broadcast write, no answer
	logic take;        // request accepted this cycle
	logic mapped;      // address exists
	logic bad_value;   // flag written with more than one
	logic wr_ok;       // write that may change state
	logic [7:0] exc;   // exception code of this request

	// answer only at our node number; broadcast only for writes
	always_comb begin
		bcast     = i_req.write && (i_req.node == `ECMR_NODE_BCAST);
		addressed = (i_req.node == node) || bcast;
		// requests before the settings are loaded are dropped
		take      = i_req.valid && addressed && (boot == ECMR_BOOT_RUN);
		mapped    = ecmr_is_mapped(i_req.addr);
		bad_value = ecmr_is_flag(i_req.addr) && (i_req.wdata > `ECMR_FLAG_MAX);
		// read-only registers refuse writes and keep their state
		wr_ok     = take && i_req.write && ecmr_is_rw(i_req.addr)
		            && !bad_value;
		if (!mapped) begin
			exc = `ECMR_EXC_ADDR;
		end else if (i_req.write && !ecmr_is_rw(i_req.addr)) begin
			exc = `ECMR_EXC_ADDR;
		end else if (i_req.write && bad_value) begin
			exc = `ECMR_EXC_VALUE;
		end else begin
			exc = `ECMR_EXC_NONE;
		end
	end

	// ==================================================
	// read multiplexer

	logic [15:0] rd_word;  // value of the addressed register

	// reserved fault bits are masked so they always read zero
	always_comb begin
		unique case (i_req.addr)
			// high half first, low half next
			`ECMR_A_HOURS_HI: rd_word = i_telem.run_hours[31:16];
			`ECMR_A_HOURS_LO: rd_word = i_telem.run_hours[15:0];
			`ECMR_A_SPEED:    rd_word = i_telem.engine_speed;
			`ECMR_A_VOLTS:    rd_word = i_telem.supply_volts_x10;
			`ECMR_A_OIL:      rd_word = i_telem.oil_kpa;
			`ECMR_A_TEMP:     rd_word = i_telem.engine_temp_c;
			// the state enum carries codes zero to sixteen
			`ECMR_A_STATE:    rd_word = 16'(i_telem.state);
			`ECMR_A_SD_A:     rd_word = i_telem.shutdown_fault_a & `ECMR_SD_A_MASK;
			`ECMR_A_SD_B:     rd_word = i_telem.shutdown_fault_b & `ECMR_SD_B_MASK;
			`ECMR_A_SD_C:     rd_word = i_telem.shutdown_fault_c & `ECMR_SD_C_MASK;
			`ECMR_A_LEVEL:    rd_word = i_telem.level_ft_x10;
			`ECMR_A_AMBIENT:  rd_word = i_telem.ambient_temp_c;
			`ECMR_A_RUN_CMD:  rd_word = 16'(work.run_cmd);
			`ECMR_A_MAX_SPD:  rd_word = work.max_speed;
			`ECMR_A_MODE:     rd_word = 16'(work.auto_mode);
			`ECMR_A_LOAD_SPD: rd_word = work.loaded_speed;
			`ECMR_A_MAN_ONLY: rd_word = 16'(work.manual_only);
			`ECMR_A_PRE1:     rd_word = 16'(work.pre1_auto_only);
			`ECMR_A_PRE2:     rd_word = 16'(work.pre2_auto_only);
			// the save register is a command and reads as zero
			default:          rd_word = `ECMR_WORD_RESET;
		endcase
	end

	// ==================================================
	// start-up: reset, then one cycle to load stored values

	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_b) begin
			boot <= ECMR_BOOT_RESET;
		end else begin
			unique case (boot)
				ECMR_BOOT_RESET: boot <= ECMR_BOOT_LOAD;
				ECMR_BOOT_LOAD:  boot <= ECMR_BOOT_RUN;
				ECMR_BOOT_RUN:   boot <= ECMR_BOOT_RUN;
			endcase
		end
	end

	// ==================================================
	// node number register

	// defaults to one; the panel may load a new number
	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_b) begin
			node <= `ECMR_NODE_DFLT;
		end else if (i_node_load) begin
			node <= i_node_cfg;
		end
	end

	// ==================================================
	// live settings

	// serial writes land here only; the stored copy is untouched,
	// so a power cycle reloads the last panel values. a local edit
	// in the same cycle as a serial write wins, being the newer
	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_b) begin
			work.run_cmd        <= `ECMR_FLAG_RESET;
			work.max_speed      <= `ECMR_WORD_RESET;
			work.auto_mode      <= `ECMR_FLAG_RESET;
			work.loaded_speed   <= `ECMR_WORD_RESET;
			work.manual_only    <= `ECMR_FLAG_RESET;
			work.pre1_auto_only <= `ECMR_FLAG_RESET;
			work.pre2_auto_only <= `ECMR_FLAG_RESET;
		end else if ((boot == ECMR_BOOT_LOAD) || i_stored_update) begin
			work <= i_stored;
		end else if (wr_ok) begin
			unique case (i_req.addr)
				// stop is zero, start is one
				`ECMR_A_RUN_CMD:  work.run_cmd        <= i_req.wdata[0];
				`ECMR_A_MAX_SPD:  work.max_speed      <= i_req.wdata;
				`ECMR_A_MODE:     work.auto_mode      <= i_req.wdata[0];
				`ECMR_A_LOAD_SPD: work.loaded_speed   <= i_req.wdata;
				`ECMR_A_MAN_ONLY: work.manual_only    <= i_req.wdata[0];
				`ECMR_A_PRE1:     work.pre1_auto_only <= i_req.wdata[0];
				`ECMR_A_PRE2:     work.pre2_auto_only <= i_req.wdata[0];
				// the save register holds nothing itself
				default:          work <= work;
			endcase
		end
	end

	// ==================================================
	// save command

	// a one in the save register hands the live settings to the
	// persistent store for one cycle; other values are ignored
	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_b) begin
			o_commit      <= 1'b0;
			o_commit_data <= '0;
		end else begin
			o_commit <= wr_ok && (i_req.addr == `ECMR_A_SAVE)
			            && (i_req.wdata == `ECMR_SAVE_VALUE);
			o_commit_data <= work;
		end
	end

	// ==================================================
	// answer to the master

	// one cycle after a taken request; broadcasts stay silent
	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_b) begin
			o_rsp <= '0;
		end else begin
			o_rsp.valid <= take && !bcast;
			o_rsp.exc   <= exc;
			// a write echoes the written word, a read the register
			o_rsp.rdata <= (i_req.write || (exc != `ECMR_EXC_NONE))
			               ? (i_req.write ? i_req.wdata : `ECMR_WORD_RESET)
			               : rd_word;
		end
	end

	// ==================================================
	// control outputs

	// the remote command only matters while in automatic mode
	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_b) begin
			o_ctrl <= '0;
		end else begin
			o_ctrl.run_request    <= work.auto_mode && work.run_cmd;
			o_ctrl.auto_mode      <= work.auto_mode;
			o_ctrl.manual_only    <= work.manual_only;
			o_ctrl.pre1_auto_only <= work.pre1_auto_only;
			o_ctrl.pre2_auto_only <= work.pre2_auto_only;
			o_ctrl.max_speed      <= work.max_speed;
			o_ctrl.loaded_speed   <= work.loaded_speed;
		end
	end

	// the node number is shown to the panel as it stands
	assign o_node = node;
endmodule : ecmr_regs
`default_nettype wire

/* File: verif/ecmr_regs_sva.sv */
// checker on the ports of the holding-register bank
// assumes: one clock, reset synchronous and active low, bound onto ecmr_regs
`timescale 1ns/1ps
`include "ecmr_defs.svh"
`default_nettype none
module ecmr_regs_sva (
	// watched ports
	input wire logic                  i_sys_clk,
	input wire logic                  i_rst_b,
	input wire ecmr_pkg::ecmr_req_t   i_req,
	input wire ecmr_pkg::ecmr_rsp_t   o_rsp,
	input wire ecmr_pkg::ecmr_telem_t i_telem,
	input wire logic                  o_commit,
	input wire ecmr_pkg::ecmr_ctrl_t  o_ctrl,
	input wire logic [7:0]            o_node
);
	// ==================================================
	// helper: the bank ignores requests until the third edge after reset
	logic [1:0] age;  // saturates at two
	logic       own;  // request addressed to this node and taken
	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_b) age <= 2'h0;
		else if (!age[1]) age <= age + 2'h1;
	end
	assign own = i_req.valid && age[1] && i_req.node == o_node;
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (!i_rst_b);
	// ==================================================
	// answer timing and refusals
	sequence s_rd(a); own && !i_req.write && i_req.addr == a; endsequence
	sequence s_save; own && i_req.write && i_req.addr == `ECMR_A_SAVE && i_req.wdata == 16'h0001;
	endsequence
	property p_answer; own |=> o_rsp.valid; endproperty
	a_answer: assert property (p_answer) else $error("request not answered");
	property p_no_stray; o_rsp.valid |-> $past(own); endproperty
	a_no_stray: assert property (p_no_stray) else $error("answer without request");
	property p_unmapped; own && !(i_req.addr inside {[16'h9C41:16'h9C53], `ECMR_A_SAVE})
		|=> o_rsp.exc == 8'h02; endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped not refused");
	property p_ro_write; own && i_req.write && i_req.addr inside {[16'h9C41:16'h9C4B], 16'h9C4E}
		|=> o_rsp.exc == 8'h02; endproperty
	a_ro_write: assert property (p_ro_write) else $error("read-only write taken");
	property p_flag_value; own && i_req.write && i_req.wdata > 16'h0001 && i_req.addr inside
		{`ECMR_A_RUN_CMD, `ECMR_A_MODE, [16'h9C51:16'h9C53]} |=> o_rsp.exc == 8'h03; endproperty
	a_flag_value: assert property (p_flag_value) else $error("bad flag value taken");
	// ==================================================
	// read data and side effects
	property p_hours; s_rd(`ECMR_A_HOURS_HI) |=> o_rsp.rdata == $past(i_telem.run_hours[31:16]);
	endproperty
	a_hours: assert property (p_hours) else $error("hours high half wrong");
	property p_fault_a; s_rd(`ECMR_A_SD_A) |=> o_rsp.rdata == ($past(i_telem.shutdown_fault_a)
		& 16'h8FFF); endproperty
	a_fault_a: assert property (p_fault_a) else $error("fault word a wrong");
	property p_commit; s_save |=> o_commit; endproperty
	a_commit: assert property (p_commit) else $error("save not committed");
	property p_commit_cause; o_commit |-> $past(i_req.valid && i_req.write
		&& i_req.addr == `ECMR_A_SAVE && i_req.wdata == 16'h0001); endproperty
	a_commit_cause: assert property (p_commit_cause) else $error("stray commit");
	property p_mode; own && i_req.write && i_req.addr == `ECMR_A_MODE && i_req.wdata == 16'h0001
		|=> ##1 o_ctrl.auto_mode; endproperty
	a_mode: assert property (p_mode) else $error("auto mode not applied");
	property p_run_gate; o_ctrl.run_request |-> o_ctrl.auto_mode; endproperty
	a_run_gate: assert property (p_run_gate) else $error("run outside auto mode");
endmodule : ecmr_regs_sva
bind ecmr_regs ecmr_regs_sva u_sva (.i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b), .i_req(i_req),
	.o_rsp(o_rsp), .i_telem(i_telem), .o_commit(o_commit), .o_ctrl(o_ctrl), .o_node(o_node));
`default_nettype wire

/* File: verif/ecmr_master_model.sv */
// serial master model: one register request per clock on the bank port
// assumes: callers enter send one nanosecond after a rising edge
`timescale 1ns/1ps
`default_nettype none
module ecmr_master_model (
	// clock
	input  wire logic              i_clk,
	// request to the bank
	output var ecmr_pkg::ecmr_req_t o_req
);
	initial o_req = '0;
	// ==================================================
	// hold one request over exactly one rising edge, then return
	task automatic send(input logic w, input logic [7:0] n, input logic [15:0] a, d);
		o_req = '{1'b1, w, n, a, d};  // node picks the slave
		@(posedge i_clk);
		#1;
	endtask : send
	// released port: fields flip so nothing can lean on stale values
	task automatic idle();
		o_req = '{1'b0, ~o_req.write, ~o_req.node, ~o_req.addr, ~o_req.wdata};
	endtask : idle
endmodule : ecmr_master_model
`default_nettype wire

/* File: verif/tb_top.sv */
// self-checking bench for the holding-register bank
// assumes: package, bank, checker and master model compiled first
`timescale 1ns/1ps
`include "ecmr_defs.svh"
`default_nettype none
module tb_top;
	// ==================================================
	// stimulus and observed ports
	logic                     clk = 1'b0;
	logic                     rst_b = 1'b0;
	logic                     nload = 1'b0;
	logic                     supd = 1'b0;
	logic [7:0]               ncfg = 8'h05;
	logic [31:0]              lf = 32'h6462;  // random source state
	logic [191:0]             w = '0;
	logic [15:0]              rwa [7] = '{16'h9C4C, 16'h9C4D, 16'h9C4F, 16'h9C50, 16'h9C51,
		16'h9C52, 16'h9C53};
	ecmr_pkg::ecmr_telem_t    tel = '0;
	ecmr_pkg::ecmr_settings_t st = '0;
	ecmr_pkg::ecmr_settings_t sv, cd;         // expected live, committed
	ecmr_pkg::ecmr_req_t      req;
	ecmr_pkg::ecmr_rsp_t      rsp;
	ecmr_pkg::ecmr_ctrl_t     ctl;
	logic                     cm;
	logic [7:0]               nd;
	logic [24:0]              q[$];           // {compare data, data, code}
	logic [24:0]              note;           // oldest note, taken off the queue
	int                       n_fail = 0;
	int                       n_tests = 0;
	always #20 clk = ~clk;
	ecmr_regs dut (.i_sys_clk(clk), .i_rst_b(rst_b), .i_req(req), .o_rsp(rsp),
		.i_node_cfg(ncfg), .i_node_load(nload), .i_telem(tel), .i_stored(st),
		.i_stored_update(supd), .o_commit_data(cd), .o_commit(cm), .o_ctrl(ctl), .o_node(nd));
	ecmr_master_model mst (.i_clk(clk), .o_req(req));
	// ==================================================
	// helpers
	function automatic logic [31:0] nx(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction : nx
	task automatic rnd();
		for (int i = 0; i < 6; i++) begin
			lf = nx(lf);
			w = {w[159:0], lf};
		end
		tel = w[180:0];
		tel.state = ecmr_pkg::ecmr_ctrl_state_t'(5'(lf[3:0]) + 5'(lf[4]));  // codes 0 to 16
	endtask : rnd
	// expected read data of every register from the telemetry and live settings
	function automatic logic [15:0] rd(input logic [15:0] a);
		logic [303:0] m;
		m = {tel.run_hours, tel.engine_speed, tel.supply_volts_x10, tel.oil_kpa,
			tel.engine_temp_c, 11'h000, tel.state, tel.shutdown_fault_a & 16'h8FFF,
			tel.shutdown_fault_b & 16'hBB9F, tel.shutdown_fault_c & 16'h0001,
			tel.level_ft_x10, 15'h0000, sv.run_cmd, sv.max_speed, tel.ambient_temp_c,
			15'h0000, sv.auto_mode, sv.loaded_speed, 15'h0000, sv.manual_only,
			15'h0000, sv.pre1_auto_only, 15'h0000, sv.pre2_auto_only};
		if (a < 16'h9C41 || a > 16'h9C53) return 16'h0000;
		return m[303 - 16 * (a - 16'h9C41) -: 16];
	endfunction : rd
	function automatic ecmr_pkg::ecmr_ctrl_t ectl(input ecmr_pkg::ecmr_settings_t s);
		return '{s.run_cmd & s.auto_mode, s.auto_mode, s.manual_only, s.pre1_auto_only,
			s.pre2_auto_only, s.max_speed, s.loaded_speed};
	endfunction : ectl
	task automatic ck(input logic ok, input string msg);
		n_tests++;
		if (ok !== 1'b1) begin
			n_fail++;
			$display("CHECK FAILED %0t %s", $time, msg);
		end
	endtask : ck
	// ans[1]: an answer is due, ans[0]: its data is compared too
	task automatic op(input logic wt, input logic [7:0] n, input logic [15:0] a, d,
		input logic [1:0] ans, input logic [15:0] r, input logic [7:0] e);
		mst.send(wt, n, a, d);
		if (ans[1]) q.push_back({ans[0], r, e});
	endtask : op
	task automatic wr(input logic [7:0] n, input logic [15:0] a, d);
		case (a)
			16'h9C4C: sv.run_cmd = d[0];
			16'h9C4D: sv.max_speed = d;
			16'h9C4F: sv.auto_mode = d[0];
			16'h9C50: sv.loaded_speed = d;
			16'h9C51: sv.manual_only = d[0];
			16'h9C52: sv.pre1_auto_only = d[0];
			default:  sv.pre2_auto_only = d[0];
		endcase
		op(1'b1, n, a, d, (n == nd) ? 2'h3 : 2'h0, d, 8'h00);
	endtask : wr
	task automatic rbk();
		for (int i = 0; i < 7; i++) op(1'b0, nd, rwa[i], 16'h0000, 2'h3, rd(rwa[i]), 8'h00);
		mst.idle();
		@(posedge clk);
		#1;
		ck(ctl === ectl(sv), "control outputs");
	endtask : rbk
	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : tally_and_finish
	// ==================================================
	// answer watcher: oldest note against each answer
	always @(posedge clk) begin
		#2;
		if (rsp.valid === 1'b1) begin
			if (q.size() == 0) begin
				ck(1'b0, "unexpected answer");
			end else begin
				note = q.pop_front();
				if (note[24]) ck(rsp[23:0] === note[23:0], "answer");
				else ck(rsp.exc === note[7:0], "answer code");
			end
		end
	end
	// watchdog: the tests need well under a thousand cycles
	initial begin
		#400000;
		n_fail++;
		tally_and_finish();
	end
	// ==================================================
	// tests
	initial begin
		rnd();
		st = w[36:0];
		sv = st;
		repeat (10) @(posedge clk);
		#1 rst_b = 1'b1;
		repeat (3) @(posedge clk);
		#1;
		ck(nd === 8'h01, "node default");
		ck(ctl === ectl(sv), "panel values after reset");
		$display("test reset done");
		for (int r = 0; r < 2; r++) begin
			for (int a = 16'h9C41; a <= 16'h9C53; a++) op(1'b0, nd, a[15:0], 16'h0000, 2'h3, rd(a[15:0]), 8'h00);
			rnd();
		end
		$display("test reads done");
		for (int r = 0; r < 4; r++) begin
			for (int i = 0; i < 7; i++) begin
				lf = nx(lf);
				wr(nd, rwa[i], (i == 1 || i == 3) ? lf[15:0] : {15'h0000, r[(i >> 1) & 1]});
			end
			rbk();
		end
		$display("test writes done");
		op(1'b1, nd, `ECMR_A_MODE, 16'h0002, 2'h2, 16'h0000, 8'h03);
		op(1'b1, nd, `ECMR_A_VOLTS, 16'h0001, 2'h2, 16'h0000, 8'h02);
		op(1'b0, nd, 16'h9C54, 16'h0000, 2'h3, 16'h0000, 8'h02);
		op(1'b0, nd, `ECMR_A_SAVE, 16'h0000, 2'h3, 16'h0000, 8'h00);
		op(1'b0, 8'h07, `ECMR_A_MODE, 16'h0000, 2'h0, 16'h0000, 8'h00);
		op(1'b0, nd, `ECMR_A_VOLTS, 16'h0000, 2'h3, rd(`ECMR_A_VOLTS), 8'h00);
		op(1'b1, nd, `ECMR_A_SAVE, 16'h0002, 2'h2, 16'h0000, 8'h00);
		ck(cm === 1'b0, "no commit on other value");
		op(1'b1, nd, `ECMR_A_SAVE, 16'h0001, 2'h2, 16'h0000, 8'h00);
		ck(cm === 1'b1 && cd === sv, "commit of live settings");
		rbk();
		$display("test refusals and save done");
		rnd();
		st = w[36:0];
		supd = 1'b1;
		@(posedge clk);
		#1 supd = 1'b0;
		sv = st;
		rbk();
		$display("test panel edit done");
		nload = 1'b1;
		@(posedge clk);
		#1 nload = 1'b0;
		ck(nd === 8'h05, "node load");
		op(1'b0, 8'h01, `ECMR_A_MODE, 16'h0000, 2'h0, 16'h0000, 8'h00);
		wr(8'h00, `ECMR_A_MAX_SPD, 16'h1234);
		rbk();
		repeat (3) @(posedge clk);
		ck(q.size() == 0, "all answers seen");
		$display("test node done");
		tally_and_finish();
	end
endmodule : tb_top
`default_nettype wire
